// [core/fssr_pkg.sv]
// Constants shared by the four-stage shift register files
`default_nettype none
package fssr_pkg;
	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int         FSSR_STAGES       = 4;
	localparam logic [3:0] FSSR_STAGE_RESET  = 4'h0;
	localparam logic [3:0] FSSR_SEED_PATTERN = 4'h1;
	localparam logic       FSSR_BIT_RESET    = 1'b0;

	// ----------------------------------------------------------------
	// Flasher timing
	// ----------------------------------------------------------------
	localparam int         FSSR_CLK_HZ       = 25000000;
	localparam int         FSSR_FLASH_MS     = 500;
	localparam int         FSSR_FLASH_CYCLES = FSSR_CLK_HZ / 1000 * FSSR_FLASH_MS;
	localparam int         FSSR_FLASH_W      = 24;
endpackage : fssr_pkg
`default_nettype wire

// [core/fssr_flasher.sv]
// Free-running flasher: toggles its output every half period
`default_nettype none
module fssr_flasher
	import fssr_pkg::*;
#(
	parameter int HALF_CYCLES = FSSR_FLASH_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// Square wave out
	output var  logic flash_q
);
	initial begin
		if (HALF_CYCLES < 1 || HALF_CYCLES > (1 << FSSR_FLASH_W))
			$error("fssr_flasher: HALF_CYCLES out of range");
	end

	logic [FSSR_FLASH_W-1:0] count_q;
	localparam logic [FSSR_FLASH_W-1:0] LAST = FSSR_FLASH_W'(HALF_CYCLES - 1);

	// ----------------------------------------------------------------
	// Counter and output toggle
	// ----------------------------------------------------------------
	// Equal on and off time, so one counter serves both phases
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
			flash_q <= 1'b0;
		end else if (count_q == LAST) begin
			count_q <= '0;
			flash_q <= ~flash_q;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end
endmodule : fssr_flasher
`default_nettype wire

// [core/fssr_shift_register.sv]
// Four-stage bit shift register with edge-made strobe and running-light mode
// Operation
// (R1) Four one-bit locations; each strobe moves values from location one toward four.
// (R2) Strobe comes from a rising edge of the pulse input, one cycle long.
// (R3) No new strobe until the pulse input has returned low.
// (R4) Strobe is registered; it acts the cycle after the edge, then clears.
// (R5) On a strobe location one takes the value input level.
// (R6) On a strobe locations two to four take their predecessor's old value.
// (R7) Between strobes all locations hold their value.
// (R8) Clear input empties all locations and wins over a shift.
// (R9) Source should encode a bad part as zero, so clearing is safe.
// (R10) Running light: one lamp on, stepping one to four, then wrapping.
// (R11) Running light: strobe source is a free-running 0.5 s on/off flasher.
// (R12) Running light: one bit injected at start; marker blocks further injection.
// (R13) Running light: after the last location, next strobe feeds location one.
// (R14) Reset clears locations, edge marker, strobe and injection marker.
`default_nettype none
module fssr_shift_register
	import fssr_pkg::*;
#(
	parameter int FLASH_HALF_CYCLES = FSSR_FLASH_CYCLES
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Mode select, pin level
	input  wire logic       run_light_in,
	// Shift register pins
	input  wire logic       shift_pulse_in,
	input  wire logic       shift_value_in,
	input  wire logic       clear_all_in,
	// Storage locations, one to four in bits 0 to 3
	output var  logic [3:0] stage_q,
	// Running-light lamps
	output var  logic       lamp_out_one,
	output var  logic       lamp_out_two,
	output var  logic       lamp_out_three,
	output var  logic       lamp_out_four,
	// Strobe for observation
	output var  logic       shift_strobe
);
	initial begin
		if (FLASH_HALF_CYCLES < 1)
			$error("fssr_shift_register: FLASH_HALF_CYCLES must be positive");
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	// First stage feeds only the second; pins are asynchronous to sys_clk
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {run_light_in, clear_all_in, shift_value_in, shift_pulse_in};
			sync2_q <= sync1_q;
		end
	end

	logic pulse_s;
	logic value_s;
	logic clear_s;
	logic mode_s;
	assign pulse_s = sync2_q[0];
	assign value_s = sync2_q[1];
	assign clear_s = sync2_q[2];
	assign mode_s  = sync2_q[3];

	// ----------------------------------------------------------------
	// Flasher as strobe source in running-light mode
	// ----------------------------------------------------------------
	logic flash_w;
	// (R11) flasher drives pulse
	fssr_flasher #(
		.HALF_CYCLES (FLASH_HALF_CYCLES)
	) u_flasher (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.flash_q (flash_w)
	);

	logic pulse_src;
	assign pulse_src = mode_s ? flash_w : pulse_s;

	// ----------------------------------------------------------------
	// Edge detector and strobe
	// ----------------------------------------------------------------
	logic edge_seen_marker_q;
	logic edge_now;
	// (R2) rising edge detect
	assign edge_now = pulse_src & ~edge_seen_marker_q;

	// (R3) marker follows input
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			edge_seen_marker_q <= FSSR_BIT_RESET;
		else
			edge_seen_marker_q <= pulse_src;
	end

	// (R4) registered one-cycle strobe
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			shift_strobe <= FSSR_BIT_RESET;
		else
			shift_strobe <= edge_now;
	end

	// ----------------------------------------------------------------
	// Injection marker for running light
	// ----------------------------------------------------------------
	logic seed_done_marker_q;
	logic inject;
	// (R12) inject once at start
	assign inject = mode_s & ~seed_done_marker_q;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			seed_done_marker_q <= FSSR_BIT_RESET;
		else if (mode_s && stage_q[0])
			seed_done_marker_q <= 1'b1;
		else if (!mode_s)
			seed_done_marker_q <= 1'b0; // Re-arm on leaving the mode
	end

	// ----------------------------------------------------------------
	// Storage locations
	// ----------------------------------------------------------------
	logic feed_bit;
	// (R13) wrap last into first
	assign feed_bit = mode_s ? (stage_q[3] | inject) : value_s;

	// Clear checked first so it beats a coincident strobe
	// (R14) reset clears locations
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			stage_q <= FSSR_STAGE_RESET;
		// (R8) clear has priority
		else if (clear_s)
			stage_q <= FSSR_STAGE_RESET;
		// (R1) shift one place
		else if (shift_strobe)
			// (R5) first takes value; (R6) others take old predecessor
			stage_q <= {stage_q[2:0], feed_bit};
		// (R7) hold between strobes
	end

	// ----------------------------------------------------------------
	// Lamp outputs
	// ----------------------------------------------------------------
	// (R10) lamps follow locations
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lamp_out_one   <= 1'b0;
			lamp_out_two   <= 1'b0;
			lamp_out_three <= 1'b0;
			lamp_out_four  <= 1'b0;
		end else begin
			lamp_out_one   <= mode_s & stage_q[0];
			lamp_out_two   <= mode_s & stage_q[1];
			lamp_out_three <= mode_s & stage_q[2];
			lamp_out_four  <= mode_s & stage_q[3];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence rise_s;
		pulse_src && !edge_seen_marker_q;
	endsequence

	strobe_follows_a: assert property ( // (R4)
		@(posedge sys_clk) disable iff (!resetn)
		rise_s |=> shift_strobe ##1 !shift_strobe)
		else $error("strobe did not follow edge for one cycle");

	strobe_cause_a: assert property ( // (R2)
		@(posedge sys_clk) disable iff (!resetn)
		shift_strobe |-> $past(pulse_src) && !$past(edge_seen_marker_q))
		else $error("strobe without rising edge");

	no_restrobe_a: assert property ( // (R3)
		@(posedge sys_clk) disable iff (!resetn)
		shift_strobe && pulse_src |=> !shift_strobe)
		else $error("second strobe while input high");

	first_loc_a: assert property ( // (R5)
		@(posedge sys_clk) disable iff (!resetn)
		shift_strobe && !clear_s && !mode_s |=> stage_q[0] == $past(value_s))
		else $error("location one missed value");

	shift_chain_a: assert property ( // (R6)
		@(posedge sys_clk) disable iff (!resetn)
		shift_strobe && !clear_s |=> stage_q[3:1] == $past(stage_q[2:0]))
		else $error("shift chain broken");

	hold_value_a: assert property ( // (R7)
		@(posedge sys_clk) disable iff (!resetn)
		!shift_strobe && !clear_s |=> $stable(stage_q))
		else $error("location changed between strobes");

	clear_wins_a: assert property ( // (R8)
		@(posedge sys_clk) disable iff (!resetn)
		clear_s |=> stage_q == 4'h0)
		else $error("clear did not empty locations");

	wrap_back_a: assert property ( // (R13)
		@(posedge sys_clk) disable iff (!resetn)
		mode_s && shift_strobe && !clear_s && stage_q[3] |=> stage_q[0])
		else $error("active bit not fed back");

	seed_once_a: assert property ( // (R12)
		@(posedge sys_clk) disable iff (!resetn)
		mode_s && seed_done_marker_q && shift_strobe && !clear_s
		|=> stage_q[0] == $past(stage_q[3]))
		else $error("bit injected after marker set");

	onehot_lamp_a: assert property ( // (R10)
		@(posedge sys_clk) disable iff (!resetn)
		mode_s && seed_done_marker_q |-> $onehot0(stage_q))
		else $error("more than one location on in running light");
endmodule : fssr_shift_register
`default_nettype wire

// [tb/fssr_field_model.sv]
// Field pushbutton model driving the pulse and value pins
`default_nettype none
module fssr_field_model (
	// Clock
	input  wire logic sys_clk,
	// Press request from the bench
	input  wire logic press_req,
	input  wire logic press_val,
	// Pins toward the block
	output var  logic pulse_pin,
	output var  logic value_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Press sequence
	// ------------------------------------------------------------
	// bad part coded as zero by caller
	// Long hold checks one strobe per edge; value flips after release
	initial begin
		pulse_pin = 1'b0;
		value_pin = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (press_req) begin
				pulse_pin <= 1'b1;
				value_pin <= press_val;
				repeat (10) @(posedge sys_clk);
				pulse_pin <= 1'b0;
				value_pin <= ~press_val;
				repeat (4) @(posedge sys_clk);
			end
		end
	end
endmodule : fssr_field_model
`default_nettype wire

// [tb/fssr_shift_register_tb_top.sv]
// Testbench for the four-stage shift register
`default_nettype none
module fssr_shift_register_tb_top import fssr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk;
	logic       resetn;
	logic       run_light_in;
	logic       clear_all_in;
	logic       press_req;
	logic       press_val;
	wire logic  shift_pulse_in;
	wire logic  shift_value_in;
	logic [3:0] stage_q;
	wire logic [3:0] lamps;
	logic       shift_strobe;
	int         errors = 0;
	int         samples_checked = 0;
	int         strobe_cnt = 0;

	// Short flasher keeps the running-light run brief
	fssr_shift_register #(.FLASH_HALF_CYCLES(4)) u_fssr_shift_register (
		.sys_clk(sys_clk), .resetn(resetn), .run_light_in(run_light_in),
		.shift_pulse_in(shift_pulse_in), .shift_value_in(shift_value_in),
		.clear_all_in(clear_all_in), .stage_q(stage_q), .lamp_out_one(lamps[0]),
		.lamp_out_two(lamps[1]), .lamp_out_three(lamps[2]), .lamp_out_four(lamps[3]),
		.shift_strobe(shift_strobe));
	fssr_field_model u_fssr_field_model (.sys_clk(sys_clk), .press_req(press_req),
		.press_val(press_val), .pulse_pin(shift_pulse_in), .value_pin(shift_value_in));

	// ------------------------------------------------------------
	// Clock and strobe counter
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (shift_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [3:0] got, input logic [3:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check
	// Returns at a falling edge with the strobe high
	task automatic wait_strobe();
		int n;
		n = 0;
		@(negedge sys_clk);
		while (shift_strobe !== 1'b1) begin
			n++;
			if (n > 200) begin
				errors++;
				$display("[FAIL] %0t strobe timeout", $time);
				finish_test();
			end
			@(negedge sys_clk);
		end
	endtask : wait_strobe

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic press(input logic v, input logic [3:0] exp, input logic clr);
		int         c0;
		logic [3:0] old;
		old = stage_q;
		c0 = strobe_cnt;
		@(posedge sys_clk);
		press_req <= 1'b1;
		press_val <= v;
		clear_all_in <= clr;
		@(posedge sys_clk);
		press_req <= 1'b0;
		wait_strobe();
		if (!clr) check(stage_q, old, "early shift");
		@(negedge sys_clk);
		check(stage_q, exp, "stage");
		check({3'h0, shift_strobe}, 4'h0, "strobe width");
		repeat (14) @(negedge sys_clk);
		check(stage_q, exp, "hold");
		check(4'(strobe_cnt - c0), 4'h1, "strobe count");
		check(lamps, 4'h0, "lamps off");
		@(posedge sys_clk);
		clear_all_in <= 1'b0;
	endtask : press
	task automatic run_light();
		logic [3:0] exp;
		exp = FSSR_SEED_PATTERN;
		repeat (3) @(posedge sys_clk);
		run_light_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wait_strobe();
			repeat (3) @(negedge sys_clk);
			check(lamps, exp, "lamp step");
			exp = {exp[2:0], exp[3]};
		end
	endtask : run_light

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		run_light_in = 1'b0;
		clear_all_in = 1'b0;
		press_req = 1'b0;
		press_val = 1'b0;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		check(stage_q, FSSR_STAGE_RESET, "reset stage");
		check(lamps, 4'h0, "reset lamps");
		check({3'h0, shift_strobe}, 4'h0, "reset strobe");
		press(1'b1, 4'h1, 1'b0);
		press(1'b0, 4'h2, 1'b0);
		press(1'b0, 4'h4, 1'b0);
		press(1'b1, 4'h9, 1'b0);
		press(1'b0, 4'h2, 1'b0);
		press(1'b1, 4'h0, 1'b1);
		run_light();
		finish_test();
	end
endmodule : fssr_shift_register_tb_top
`default_nettype wire
